// *** pkg/move_core_pkg.sv ***
// Constants and carrier types for the move instruction decoder
package move_core_pkg;
	// Instruction word fields
	localparam int FMT_BIT = 15;
	localparam int SRC_LSB = 0;
	localparam int DST_LSB = 8;
	localparam int DST_IDX_LSB = 12;
	// Module specifiers
	localparam logic [3:0] MOD_AP = 4'h8;
	localparam logic [3:0] MOD_ACC = 4'h9;
	localparam logic [3:0] MOD_PREFIX = 4'hb;
	localparam logic [3:0] MOD_IP = 4'hc;
	localparam logic [3:0] MOD_STACK = 4'hd;
	localparam logic [3:0] MOD_DPC = 4'he;
	localparam logic [3:0] MOD_DP = 4'hf;
	// Register indices
	localparam logic [4:0] IDX_IP = 5'h00;
	localparam logic [4:0] IDX_STK_TOP = 5'h01;
	localparam logic [4:0] IDX_PUSH = 5'h00;
	localparam logic [4:0] IDX_DP0 = 5'h03;
	localparam logic [4:0] IDX_DP1 = 5'h07;
	localparam logic [4:0] IDX_BP = 5'h07;
	localparam logic [4:0] IDX_DPCFG = 5'h04;
	localparam logic [4:0] IDX_MEMMODE = 5'h08;
	localparam logic [4:0] IDX_AP = 5'h00;
	// Resets and sizes
	localparam logic [1:0] STACK_RST = 2'h3;
	localparam int STACK_DEPTH = 4;
	localparam int ACC_COUNT = 16;
	localparam int UROM_WORDS = 2048;
	localparam int PROG_WORDS = 1024;
	localparam int DEE_BYTES = 128;
	localparam int SRAM_BYTES = 64;
	localparam int KEY_WORDS = 16;
	localparam logic [15:0] UROM_BASE = 16'h8000;
	localparam logic [15:0] DATA_IN_CODE_BASE = 16'h0400;
	localparam logic [15:0] CODE_IN_DATA_BASE = 16'h8000;
	localparam logic [15:0] KEY_BASE = 16'h0010;
	// Decoded move
	typedef struct packed {
		logic imm;
		logic [7:0] src;
		logic [3:0] dst_mod;
		logic [4:0] dst_idx;
	} move_t;
	// Memory access request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_req_t;
endpackage

// *** core/move_field_decode.sv ***
// Field decoder for one move instruction word
`timescale 1ns/1ps
module move_field_decode (
	// Instruction and prefix
	input wire logic [15:0] instr,
	input wire logic [1:0] prefix,
	// Decoded move
	output move_core_pkg::move_t mv
);
	assign mv.imm = instr[move_core_pkg::FMT_BIT];
	assign mv.src = instr[move_core_pkg::SRC_LSB +: 8];
	assign mv.dst_mod = instr[move_core_pkg::DST_LSB +: 4];
	assign mv.dst_idx = {prefix, instr[move_core_pkg::DST_IDX_LSB +: 3]};
endmodule

// *** core/move_instruction_decoder.sv ***
// Move instruction decoder and single-cycle execution control
`timescale 1ns/1ps
module move_instruction_decoder #(
	parameter int KEY_WORDS = move_core_pkg::KEY_WORDS,
	parameter int STACK_DEPTH = move_core_pkg::STACK_DEPTH
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Program memory
	output logic [15:0] PROG_ADDR,
	input wire logic [15:0] PROG_DATA,
	// Data memory and peripherals
	output move_core_pkg::mem_req_t DATA_REQ,
	input wire logic [15:0] DATA_RDATA,
	// Peripheral register source read
	output logic [7:0] PERIPH_SRC,
	input wire logic [15:0] PERIPH_RDATA,
	// Peripheral register destination write
	output logic PERIPH_WE,
	output logic [8:0] PERIPH_DST,
	output logic [15:0] PERIPH_WDATA,
	// Password key match and status
	input wire logic KEY_OK,
	output logic CODE_LOCKED,
	output logic [1:0] MEM_MODE,
	output logic [7:0] ACC_OUT
);
	localparam int SW = $clog2(STACK_DEPTH);
	logic [15:0] ip_q, ip_d;
	logic [1:0] pfx_q, pfx_d;
	logic [SW-1:0] sp_q, sp_d;
	logic [15:0] stk_q [STACK_DEPTH];
	logic [15:0] dp_q [3];
	logic [1:0] dpsel_q;
	logic [5:0] dpcfg_q;
	logic [3:0] ap_q;
	logic [7:0] acc_q [move_core_pkg::ACC_COUNT];
	logic [1:0] mode_q;
	logic unlock_q;
	move_core_pkg::move_t mv;

	move_field_decode u_dec (
		.instr(PROG_DATA),
		.prefix(pfx_q),
		.mv(mv)
	);

	// Source decode
	wire [3:0] smod = mv.src[3:0];
	wire [4:0] sidx = {1'b0, mv.src[7:4]};
	wire src_acc = !mv.imm && smod == move_core_pkg::MOD_ACC;
	wire src_ip = !mv.imm && smod == move_core_pkg::MOD_IP;
	wire src_pop = !mv.imm && smod == move_core_pkg::MOD_STACK && sidx == move_core_pkg::IDX_PUSH;
	wire src_sp = !mv.imm && smod == move_core_pkg::MOD_STACK && sidx == move_core_pkg::IDX_STK_TOP;
	wire src_mem = !mv.imm && smod == move_core_pkg::MOD_DP;
	wire src_per = !mv.imm && !(src_acc | src_ip | src_pop | src_sp | src_mem);
	wire [15:0] src_val = mv.imm ? {8'h00, mv.src} :
		src_acc ? {8'h00, acc_q[sidx[3:0]]} :
		src_ip ? ip_q :
		src_pop ? stk_q[sp_q] :
		src_sp ? {{(16 - SW){1'b0}}, sp_q} :
		src_mem ? DATA_RDATA : PERIPH_RDATA;

	// Destination decode
	wire [3:0] dm = mv.dst_mod;
	wire [4:0] di = mv.dst_idx;
	wire d_ap = dm == move_core_pkg::MOD_AP && di == move_core_pkg::IDX_AP;
	wire d_mode = dm == move_core_pkg::MOD_AP && di == move_core_pkg::IDX_MEMMODE;
	wire d_acc = dm == move_core_pkg::MOD_ACC && di < 5'd16;
	wire d_pfx = dm == move_core_pkg::MOD_PREFIX && di < 5'd8;
	wire d_jump = dm == move_core_pkg::MOD_IP && di == move_core_pkg::IDX_IP;
	wire d_push = dm == move_core_pkg::MOD_STACK && di == move_core_pkg::IDX_PUSH;
	wire d_sp = dm == move_core_pkg::MOD_STACK && di == move_core_pkg::IDX_STK_TOP;
	wire d_dpcfg = dm == move_core_pkg::MOD_DPC && di == move_core_pkg::IDX_DPCFG;
	wire d_bp = dm == move_core_pkg::MOD_DPC && di == move_core_pkg::IDX_BP;
	wire d_dp0 = dm == move_core_pkg::MOD_DP && di == move_core_pkg::IDX_DP0;
	wire d_dp1 = dm == move_core_pkg::MOD_DP && di == move_core_pkg::IDX_DP1;
	wire d_mem = dm == move_core_pkg::MOD_DP && di == 5'h00;
	wire d_core = dm[3];
	// Peripheral writes only below core modules
	wire d_per = !d_core;
	wire [7:0] alu_b = src_val[7:0];

	// Pointer step: cfg bit 2*ds enable, bit 2*ds+1 down, bit5 pre
	wire [1:0] ds = dpsel_q == 2'd3 ? 2'd0 : dpsel_q;
	wire [1:0] dcfg = dpcfg_q[2*ds +: 2];
	wire [15:0] dp_step = dcfg[1] ? dp_q[ds] - 16'h0001 : dp_q[ds] + 16'h0001;
	wire mem_acc = src_mem | d_mem;
	wire pre_step = dcfg[0] && dpcfg_q[5];
	wire [15:0] dp_addr = pre_step ? dp_step : dp_q[ds];

	// Data into code space in mode bit0
	wire [15:0] data_addr_mapped = dp_addr - move_core_pkg::DATA_IN_CODE_BASE;
	// Program words end where data begins
	wire past_code = ip_q >= 16'(move_core_pkg::PROG_WORDS);
	wire fetch_data = mode_q[0] && past_code && ip_q < move_core_pkg::UROM_BASE;
	// Code into data space in mode bit1
	wire mem_is_code = mode_q[1] && dp_addr >= move_core_pkg::CODE_IN_DATA_BASE;
	wire [15:0] code_off = dp_addr - move_core_pkg::CODE_IN_DATA_BASE;
	wire key_area = code_off >= move_core_pkg::KEY_BASE
		&& code_off < move_core_pkg::KEY_BASE + 16'(KEY_WORDS);
	wire mem_allowed = !(mem_is_code && key_area && !unlock_q);

	// Fetch address is IP, less the data base when fetching data in mode bit0
	assign PROG_ADDR = fetch_data ? ip_q - move_core_pkg::DATA_IN_CODE_BASE : ip_q;
	assign DATA_REQ.rd = src_mem && mem_allowed;
	assign DATA_REQ.wr = d_mem && mem_allowed;
	assign DATA_REQ.addr = mem_is_code ? dp_addr : data_addr_mapped + move_core_pkg::DATA_IN_CODE_BASE;
	assign DATA_REQ.wdata = src_val;
	assign PERIPH_SRC = src_per ? mv.src : 8'h00;
	assign PERIPH_WE = d_per;
	assign PERIPH_DST = {dm, di};
	assign PERIPH_WDATA = src_val;
	assign CODE_LOCKED = !unlock_q;
	assign MEM_MODE = mode_q;
	assign ACC_OUT = acc_q[ap_q];

	// Prefix taken only from this instruction
	assign pfx_d = d_pfx ? src_val[1:0] : 2'b00;
	assign ip_d = d_jump ? src_val : ip_q + 16'h0001;
	assign sp_d = d_push ? sp_q + SW'(1) : src_pop ? sp_q - SW'(1) :
		d_sp ? src_val[SW-1:0] : sp_q;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ip_q <= 16'h0000;
			pfx_q <= 2'b00;
			sp_q <= SW'(move_core_pkg::STACK_RST);
		end else begin
			ip_q <= ip_d;
			pfx_q <= pfx_d;
			sp_q <= sp_d;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < STACK_DEPTH; i++) stk_q[i] <= 16'h0000;
		end else if (d_push) begin
			stk_q[sp_q + SW'(1)] <= src_val;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < 3; i++) dp_q[i] <= 16'h0000;
			dpsel_q <= 2'd0;
			dpcfg_q <= 6'h00;
		end else begin
			if (d_dp0) begin
				dp_q[0] <= src_val;
				dpsel_q <= 2'd0;
			end else if (d_dp1) begin
				dp_q[1] <= src_val;
				dpsel_q <= 2'd1;
			end else if (d_bp) begin
				dp_q[2] <= src_val;
				dpsel_q <= 2'd2;
			end else if (mem_acc && dcfg[0]) begin
				dp_q[ds] <= dp_step;
			end
			if (d_dpcfg) dpcfg_q <= src_val[5:0];
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < move_core_pkg::ACC_COUNT; i++) acc_q[i] <= 8'h00;
			ap_q <= 4'h0;
		end else begin
			if (d_acc) acc_q[di[3:0]] <= alu_b;
			if (d_ap) ap_q <= src_val[3:0];
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			mode_q <= 2'b00;
			unlock_q <= 1'b0;
		end else begin
			if (d_mode) mode_q <= src_val[1:0];
			if (KEY_OK) unlock_q <= 1'b1;
		end
	end
endmodule

// *** verification/move_far_side.sv ***
// Program memory and peripheral register model
`timescale 1ns/1ps
module move_far_side (
	// Program memory
	input wire logic [15:0] prog_addr,
	output logic [15:0] prog_data,
	// Data memory
	input wire move_core_pkg::mem_req_t data_req,
	output logic [15:0] data_rdata,
	// Peripheral reads
	input wire logic [7:0] periph_src,
	output logic [15:0] periph_rdata
);
	logic [15:0] mem [0:255];
	assign prog_data = mem[prog_addr[7:0]];
	// Idle data bus shows a changing pattern
	assign data_rdata = data_req.rd ? ~data_req.addr : {8'ha5, prog_addr[7:0]};
	// Peripheral value echoes its specifier
	assign periph_rdata = {periph_src[3:0], 4'h0, periph_src};
endmodule

// *** verification/move_instruction_decoder_chk.sv ***
// Port checker for the move instruction decoder
`timescale 1ns/1ps
module move_instruction_decoder_chk (
	// Clock, reset, program
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [15:0] PROG_ADDR,
	input wire logic [15:0] PROG_DATA,
	// Outputs and key
	input wire logic PERIPH_WE,
	input wire logic [8:0] PERIPH_DST,
	input wire logic [15:0] PERIPH_WDATA,
	input wire logic KEY_OK,
	input wire logic CODE_LOCKED,
	input wire logic [1:0] MEM_MODE,
	input wire logic [7:0] ACC_OUT
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	sequence s_pfx;
		PROG_DATA[15:8] == 8'h8b;
	endsequence
	sequence s_plain;
		PROG_DATA[11:8] != 4'hb;
	endsequence
	a_we_module: assert property (PERIPH_WE == !PROG_DATA[11])
		else $error("write strobe wrong");
	a_dst_fields: assert property (PERIPH_WE |-> PERIPH_DST[8:5] == PROG_DATA[11:8]
		&& PERIPH_DST[2:0] == PROG_DATA[14:12]) else $error("destination wrong");
	a_imm_source: assert property (PERIPH_WE && PROG_DATA[15]
		|-> PERIPH_WDATA == {8'h00, PROG_DATA[7:0]}) else $error("immediate wrong");
	a_seq_fetch: assert property (PERIPH_WE && MEM_MODE == 2'h0
		|=> PROG_ADDR == $past(PROG_ADDR) + 16'h1) else $error("fetch not sequential");
	a_reset_state: assert property ($rose(RST_N) |-> PROG_ADDR == 16'h0
		&& CODE_LOCKED && MEM_MODE == 2'h0) else $error("reset state wrong");
	a_prefix_used: assert property (s_pfx ##1 PERIPH_WE
		|-> PERIPH_DST[4:3] == $past(PROG_DATA[1:0])) else $error("prefix not applied");
	a_prefix_once: assert property (s_pfx ##1 s_plain ##1 PERIPH_WE
		|-> PERIPH_DST[4:3] == 2'h0) else $error("prefix lingers");
	a_unimpl_quiet: assert property (PROG_DATA[11:8] == 4'ha && MEM_MODE == 2'h0
		|=> $stable(MEM_MODE) && $stable(ACC_OUT)) else $error("unmapped write acted");
	a_jump_target: assert property (PROG_DATA[15:8] == 8'h8c && MEM_MODE == 2'h0
		|=> PROG_ADDR == {8'h00, $past(PROG_DATA[7:0])}) else $error("jump wrong");
	a_lock_sticky: assert property (KEY_OK || !CODE_LOCKED |=> !CODE_LOCKED)
		else $error("lock not cleared");
endmodule
bind move_instruction_decoder move_instruction_decoder_chk chk (.MCLK(MCLK), .RST_N(RST_N),
	.PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA), .PERIPH_WE(PERIPH_WE),
	.PERIPH_DST(PERIPH_DST), .PERIPH_WDATA(PERIPH_WDATA), .KEY_OK(KEY_OK),
	.CODE_LOCKED(CODE_LOCKED), .MEM_MODE(MEM_MODE), .ACC_OUT(ACC_OUT));

// *** verification/move_instruction_decoder_bench.sv ***
// Self-checking bench for the move instruction decoder
`timescale 1ns/1ps
module move_instruction_decoder_bench;
	logic MCLK = 1'b0;
	logic RST_N = 1'b0;
	logic KEY_OK = 1'b0;
	logic [15:0] pa, pd, drd, prd, pwd;
	move_core_pkg::mem_req_t dreq;
	logic [7:0] psrc, acc;
	logic pwe, locked;
	logic [8:0] pdst;
	logic [1:0] mode;
	int num_errors = 0;
	int check_count = 0;
	initial begin
		forever #12.5 MCLK = ~MCLK;
	end
	move_instruction_decoder dut (.MCLK(MCLK), .RST_N(RST_N), .PROG_ADDR(pa), .PROG_DATA(pd),
		.DATA_REQ(dreq), .DATA_RDATA(drd), .PERIPH_SRC(psrc), .PERIPH_RDATA(prd),
		.PERIPH_WE(pwe), .PERIPH_DST(pdst), .PERIPH_WDATA(pwd), .KEY_OK(KEY_OK),
		.CODE_LOCKED(locked), .MEM_MODE(mode), .ACC_OUT(acc));
	move_far_side far (.prog_addr(pa), .prog_data(pd), .data_req(dreq), .data_rdata(drd),
		.periph_src(psrc), .periph_rdata(prd));
	task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic restart(input logic [15:0] prog [16]);
		@(posedge MCLK);
		RST_N <= 1'b0;
		for (int i = 0; i < 256; i++) far.mem[i] <= (i < 16) ? prog[i] : 16'h8100;
		repeat (3) @(posedge MCLK);
		RST_N <= 1'b1;
		@(negedge MCLK);
	endtask
	task automatic t_moves();
		restart('{16'h8255, 16'h011d, 16'h0132, 16'hf501, 16'h8b03, 16'h9604, 16'h9604,
			16'h8a77, 16'h8942, 16'h8c0b, 16'h8100, 16'h8b01, 16'h8802, 16'h8b01, 16'h8801,
			16'h8100});
		chk("addr", 16'h0, pa);
		chk("dst", 16'h040, pdst);
		chk("imm", 16'h0055, pwd);
		@(negedge MCLK);
		chk("sp", 16'h3, pwd);
		chk("fetch", 16'h1, pa);
		@(negedge MCLK);
		chk("src", 16'h32, psrc);
		chk("rdata", 16'h2032, pwd);
		@(negedge MCLK);
		chk("sub", 16'h0a7, pdst);
		@(negedge MCLK);
		chk("pfx we", 16'h0, pwe);
		@(negedge MCLK);
		chk("pfx dst", 16'h0d9, pdst);
		@(negedge MCLK);
		chk("no pfx", 16'h0c1, pdst);
		@(negedge MCLK);
		chk("unmap we", 16'h0, pwe);
		@(negedge MCLK);
		chk("unmap acc", 16'h0, acc);
		@(negedge MCLK);
		chk("acc", 16'h42, acc);
		@(negedge MCLK);
		chk("jump", 16'h000b, pa);
		repeat (2) @(negedge MCLK);
		chk("mode2", 16'h2, mode);
		repeat (2) @(negedge MCLK);
		chk("mode1", 16'h1, mode);
	endtask
	task automatic t_pointers();
		restart('{16'hbf20, 16'hce01, 16'h8f77, 16'h010f, 16'hce23, 16'h010f, 16'h8b01,
			16'h8802, 16'hce00, 16'h3f18, 16'h010f, 16'h010f, 16'h010f, 16'h8100, 16'h8100,
			16'h8100});
		repeat (2) @(negedge MCLK);
		chk("mem wr", 16'h1, dreq.wr);
		chk("wr addr", 16'h0020, dreq.addr);
		chk("wr data", 16'h0077, dreq.wdata);
		@(negedge MCLK);
		chk("mem rd", 16'h1, dreq.rd);
		chk("post step", 16'h0021, dreq.addr);
		chk("rd data", 16'hffde, pwd);
		repeat (2) @(negedge MCLK);
		chk("pre step", 16'h0021, dreq.addr);
		repeat (5) @(negedge MCLK);
		chk("code mode", 16'h2, mode);
		chk("key addr", 16'h8018, dreq.addr);
		chk("key blocked", 16'h0, dreq.rd);
		@(posedge MCLK);
		KEY_OK <= 1'b1;
		@(posedge MCLK);
		KEY_OK <= 1'b0;
		@(negedge MCLK);
		chk("key open", 16'h1, dreq.rd);
		chk("code data", 16'h7fe7, pwd);
	endtask
	task automatic t_stack();
		restart('{16'h8d11, 16'h8d22, 16'h8d33, 16'h8d44, 16'h010d, 16'h010d, 16'h010d,
			16'h010d, 16'h011d, 16'h8100, 16'h8100, 16'h8100, 16'h8100, 16'h8100, 16'h8100,
			16'h8100});
		chk("locked", 16'h1, locked);
		repeat (4) @(negedge MCLK);
		for (int i = 0; i < 4; i++) begin
			chk("pop", 16'h44 - 16'h11 * i[15:0], pwd);
			@(negedge MCLK);
		end
		chk("sp back", 16'h3, pwd);
		@(posedge MCLK);
		KEY_OK <= 1'b1;
		@(posedge MCLK);
		KEY_OK <= 1'b0;
		repeat (3) @(negedge MCLK);
		chk("unlocked", 16'h0, locked);
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		t_moves();
		t_pointers();
		t_stack();
		report_and_stop();
	end
	initial begin
		#(25 * 400);
		num_errors++;
		report_and_stop();
	end
endmodule
